// ==== rx_mode_bist_consts.svh ====
// Offsets, field positions, reset values and timing counts
`ifndef RX_MODE_BIST_CONSTS_SVH
`define RX_MODE_BIST_CONSTS_SVH

`define OFS_RX_MODE 8'h20
`define OFS_SELF_TEST 8'h24
`define OFS_STATUS 8'h2c
`define RX_MODE_RST 8'h20
`define SELF_TEST_RST 8'h08

`define STAT_ACTIVE 0
`define STAT_SETTLE 1
`define STAT_ERR 2
`define STAT_FREQ_OK 3

`define FREQ_RSVD 2'h3
`define CLKSRC_EXT 2'h0
`define BC_DIV_SLOW 4
`define BC_DIV_MID 2

`define CLK_PERIOD_PS 4000
`define BC_FAST_PERIOD_PS 50000
`define BC_FAST_DIV \
  ((`BC_FAST_PERIOD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BC_SETTLE_NS 1000
`define BC_SETTLE_CYC \
  ((`BC_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== rx_mode_bist_pkg.sv ====
// Types shared by the mode and self-test register block
package rx_mode_bist_pkg;

  typedef struct packed {
    logic fast;
    logic coax;
    logic repeater;
  } strap_t;

  typedef struct packed {
    logic rate_sel;
    logic audio_auto;
    logic fast_en;
    logic coax;
    logic repeater;
    logic [1:0] rsvd;
  } rx_mode_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] freq;
    logic pin_cfg;
    logic [1:0] clk_src;
    logic en;
  } self_test_t;

  typedef struct packed {
    logic valid;
    logic [1:0] clk_src;
    logic int_clk;
  } remote_cmd_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;

endpackage

// ==== backchan_rate_gen.sv ====
// Back-channel bit-rate tick generator
`include "rx_mode_bist_consts.svh"

module backchan_rate_gen #(
  parameter int FAST_DIV = `BC_FAST_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_div_tick,
  input wire logic rate_sel,
  input wire logic fast_en,
  output logic bc_tick
);

  localparam int CW = $clog2(FAST_DIV + 1);
  localparam logic [CW-1:0] FAST_LAST = CW'(FAST_DIV - 1);
  localparam logic [CW-1:0] SLOW_LAST = CW'(`BC_DIV_SLOW - 1);
  localparam logic [CW-1:0] MID_LAST = CW'(`BC_DIV_MID - 1);

  logic [CW-1:0] cnt;
  logic [1:0] key;
  logic [1:0] key_q;
  logic [CW-1:0] last;

  assign key = fast_en ? 2'b10 : {1'b0, rate_sel};
  assign last = rate_sel ? MID_LAST : SLOW_LAST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      bc_tick <= 1'b0;
      key_q <= 2'b00;
    end else begin
      key_q <= key;
      if (key != key_q) begin
        cnt <= '0;
        bc_tick <= 1'b0;
      end else if (fast_en) begin
        bc_tick <= (cnt == FAST_LAST);
        cnt <= (cnt == FAST_LAST) ? '0 : cnt + 1'b1;
      end else if (osc_div_tick) begin
        bc_tick <= (cnt >= last);
        cnt <= (cnt >= last) ? '0 : cnt + 1'b1;
      end else begin
        bc_tick <= 1'b0;
      end
    end
  end

  property p_fast_period;
    @(posedge hclk) disable iff (!hresetn)
    (fast_en && bc_tick) |-> ##13 (bc_tick || !fast_en);
  endproperty
  a_fast_period: assert property (p_fast_period)
    else $error("fast back-channel tick spacing wrong");

  property p_slow_on_osc;
    @(posedge hclk) disable iff (!hresetn)
    (bc_tick && !fast_en && $past(!fast_en)) |-> $past(osc_div_tick);
  endproperty
  a_slow_on_osc: assert property (p_slow_on_osc)
    else $error("divided tick without oscillator tick");

endmodule

// ==== rx_mode_bist_regs.sv ====
// Receiver-mode and self-test control registers on AHB-Lite
//
// Chosen here: register access over AHB-Lite.
`include "rx_mode_bist_consts.svh"

module rx_mode_bist_regs #(
  parameter int AUD_W = 2,
  parameter int SETTLE_CYC = `BC_SETTLE_CYC,
  parameter int FAST_DIV = `BC_FAST_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire rx_mode_bist_pkg::strap_t mode_strap_pin,
  input wire logic self_test_pin,
  input wire logic auto_clk_en,
  input wire logic osc_div_tick,
  input wire logic backchan_err,
  input wire logic aux_code_valid,
  input wire logic [AUD_W-1:0] aux_audio_mode,
  output logic backchan_tick,
  output logic backchan_fast_en,
  output logic backchan_settling,
  output logic cable_coax,
  output logic audio_auto,
  output logic [AUD_W-1:0] audio_mode,
  output logic [1:0] osc_rx_clk_freq,
  output logic osc_freq_valid,
  output logic self_test_active,
  output rx_mode_bist_pkg::remote_cmd_t remote_cmd
);

  localparam int SW = 12;
  localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYC);

  rx_mode_bist_pkg::rx_mode_t mode;
  rx_mode_bist_pkg::self_test_t bist;
  rx_mode_bist_pkg::bus_state_t state;
  rx_mode_bist_pkg::bus_state_t next_state;

  logic [7:0] addr_q;
  logic accept;
  logic wr_mode;
  logic wr_bist;
  logic wr_stat;
  logic [31:0] rd_data;
  logic strap_done;
  logic [1:0] rate_key;
  logic [1:0] rate_key_q;
  logic [SW-1:0] settle_cnt;
  logic err_seen;
  logic err_clr;
  logic eff_en;

  ////////////////////////////////////////////////////////////////
  // Bus slave

  assign accept = hsel && hready && htrans[1];

  always_comb begin
    next_state = rx_mode_bist_pkg::BUS_IDLE;
    if (accept) begin
      if (hwrite) begin
        next_state = rx_mode_bist_pkg::BUS_WRITE;
      end else begin
        next_state = rx_mode_bist_pkg::BUS_READ;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= rx_mode_bist_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      case (state)
        rx_mode_bist_pkg::BUS_READ: begin
          hrdata <= rd_data;
          hreadyout <= 1'b1;
          state <= rx_mode_bist_pkg::BUS_IDLE;
        end
        rx_mode_bist_pkg::BUS_IDLE,
        rx_mode_bist_pkg::BUS_WRITE: begin
          state <= next_state;
          if (accept) begin
            addr_q <= haddr[7:0];
          end
          // Reads take one wait state so a write just done shows
          hreadyout <= !(accept && !hwrite);
        end
        default: begin
          state <= rx_mode_bist_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  assign wr_mode = (state == rx_mode_bist_pkg::BUS_WRITE) &&
                   (addr_q == `OFS_RX_MODE);
  assign wr_bist = (state == rx_mode_bist_pkg::BUS_WRITE) &&
                   (addr_q == `OFS_SELF_TEST);
  assign wr_stat = (state == rx_mode_bist_pkg::BUS_WRITE) &&
                   (addr_q == `OFS_STATUS);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (addr_q)
      `OFS_RX_MODE: begin
        rd_data[6:0] = mode;
      end
      `OFS_SELF_TEST: begin
        rd_data[7:0] = bist;
      end
      `OFS_STATUS: begin
        rd_data[`STAT_ACTIVE] = self_test_active;
        rd_data[`STAT_SETTLE] = backchan_settling;
        rd_data[`STAT_ERR] = err_seen;
        rd_data[`STAT_FREQ_OK] = osc_freq_valid;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Receiver-mode register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= 7'(`RX_MODE_RST);
    end else if (!strap_done) begin
      mode.fast_en <= mode_strap_pin.fast;
      mode.coax <= mode_strap_pin.coax;
      mode.repeater <= mode_strap_pin.repeater;
    end else if (wr_mode) begin
      mode.rate_sel <= hwdata[6];
      mode.audio_auto <= hwdata[5];
      mode.fast_en <= hwdata[4];
      mode.coax <= hwdata[3];
      mode.rsvd <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cable_coax <= 1'b0;
      backchan_fast_en <= 1'b0;
      audio_auto <= 1'b0;
      audio_mode <= '0;
    end else begin
      cable_coax <= mode.coax;
      backchan_fast_en <= mode.fast_en;
      audio_auto <= mode.audio_auto;
      if (mode.audio_auto && aux_code_valid) begin
        audio_mode <= aux_audio_mode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Back-channel rate and error masking

  backchan_rate_gen #(
    .FAST_DIV(FAST_DIV)
  ) u_rate (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_div_tick(osc_div_tick),
    .rate_sel(mode.rate_sel),
    .fast_en(mode.fast_en),
    .bc_tick(backchan_tick)
  );

  assign rate_key = mode.fast_en ? 2'b10 : {1'b0, mode.rate_sel};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_key_q <= 2'b00;
      settle_cnt <= '0;
      backchan_settling <= 1'b0;
    end else begin
      rate_key_q <= rate_key;
      if (strap_done && rate_key != rate_key_q) begin
        settle_cnt <= SETTLE_LOAD;
        backchan_settling <= 1'b1;
      end else if (settle_cnt != '0) begin
        settle_cnt <= settle_cnt - 1'b1;
        backchan_settling <= (settle_cnt != SW'(1));
      end else begin
        backchan_settling <= 1'b0;
      end
    end
  end

  assign err_clr = wr_stat && hwdata[`STAT_ERR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_seen <= 1'b0;
    end else if (backchan_err && !backchan_settling) begin
      err_seen <= 1'b1;
    end else if (err_clr) begin
      err_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Self-test control register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bist <= `SELF_TEST_RST;
    end else if (wr_bist) begin
      bist <= hwdata[7:0];
    end
  end

  assign eff_en = bist.pin_cfg ? self_test_pin : bist.en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      self_test_active <= 1'b0;
      remote_cmd <= '0;
    end else begin
      self_test_active <= eff_en;
      remote_cmd.valid <= eff_en && !self_test_active;
      if (eff_en && !self_test_active) begin
        remote_cmd.clk_src <= bist.clk_src;
        remote_cmd.int_clk <= (bist.clk_src != `CLKSRC_EXT);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_freq_valid <= 1'b0;
      osc_rx_clk_freq <= 2'b00;
    end else begin
      osc_freq_valid <= auto_clk_en && (bist.freq != `FREQ_RSVD);
      if (auto_clk_en && (bist.freq != `FREQ_RSVD)) begin
        osc_rx_clk_freq <= bist.freq;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks

  property p_strap_fast;
    @(posedge hclk) disable iff (!hresetn)
    $rose(strap_done) |-> mode.fast_en == $past(mode_strap_pin.fast);
  endproperty
  a_strap_fast: assert property (p_strap_fast)
    else $error("fast bit not taken from strap");

  property p_strap_coax;
    @(posedge hclk) disable iff (!hresetn)
    $rose(strap_done) |-> ##1 cable_coax == $past(mode_strap_pin.coax, 2);
  endproperty
  a_strap_coax: assert property (p_strap_coax)
    else $error("cable bit not taken from strap");

  property p_repeater_ro;
    @(posedge hclk) disable iff (!hresetn)
    (strap_done && $past(strap_done)) |-> $stable(mode.repeater);
  endproperty
  a_repeater_ro: assert property (p_repeater_ro)
    else $error("repeater bit changed after strap load");

  property p_audio_follow;
    @(posedge hclk) disable iff (!hresetn)
    (mode.audio_auto && aux_code_valid) |=>
      audio_mode == $past(aux_audio_mode);
  endproperty
  a_audio_follow: assert property (p_audio_follow)
    else $error("audio mode did not follow aux code");

  property p_freq_rsvd;
    @(posedge hclk) disable iff (!hresetn)
    (bist.freq == `FREQ_RSVD) |=> !osc_freq_valid;
  endproperty
  a_freq_rsvd: assert property (p_freq_rsvd)
    else $error("reserved receive clock code applied");

  property p_pin_ctrl;
    @(posedge hclk) disable iff (!hresetn)
    bist.pin_cfg |=> self_test_active == $past(self_test_pin);
  endproperty
  a_pin_ctrl: assert property (p_pin_ctrl)
    else $error("self-test not following pin");

  property p_reg_ctrl;
    @(posedge hclk) disable iff (!hresetn)
    wr_bist |=> ##1 (bist.pin_cfg || self_test_active == $past(hwdata[0], 2));
  endproperty
  a_reg_ctrl: assert property (p_reg_ctrl)
    else $error("self-test not following enable bit");

  property p_send_src;
    @(posedge hclk) disable iff (!hresetn)
    $rose(self_test_active) |->
      remote_cmd.valid && remote_cmd.clk_src == $past(bist.clk_src)
      ##1 !remote_cmd.valid;
  endproperty
  a_send_src: assert property (p_send_src)
    else $error("clock source not sent on enable");

  property p_int_clk;
    @(posedge hclk) disable iff (!hresetn)
    remote_cmd.valid |->
      remote_cmd.int_clk == (remote_cmd.clk_src != `CLKSRC_EXT);
  endproperty
  a_int_clk: assert property (p_int_clk)
    else $error("clock source decode wrong");

  property p_err_mask;
    @(posedge hclk) disable iff (!hresetn)
    (backchan_err && backchan_settling && !err_clr) |=>
      err_seen == $past(err_seen);
  endproperty
  a_err_mask: assert property (p_err_mask)
    else $error("error counted while settling");

  property p_settle_len;
    @(posedge hclk) disable iff (!hresetn)
    (strap_done && rate_key != rate_key_q) |=>
      backchan_settling [*8];
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("settle window too short");

  property p_rsvd_store;
    @(posedge hclk) disable iff (!hresetn)
    wr_bist |=> bist.rsvd == $past(hwdata[7:6]);
  endproperty
  a_rsvd_store: assert property (p_rsvd_store)
    else $error("reserved bits not stored");

  property p_fast_out;
    @(posedge hclk) disable iff (!hresetn)
    $changed(mode.rate_sel) && mode.fast_en && $past(mode.fast_en) |=>
      !backchan_settling || $past(backchan_settling);
  endproperty
  a_fast_out: assert property (p_fast_out)
    else $error("rate select acted while fast");

endmodule

// ==== remote_serializer_model.sv ====
// Far-end serializer model: clock-source store, error and aux sources
module remote_serializer_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire rx_mode_bist_pkg::remote_cmd_t remote_cmd,
  input wire logic auto_ack_req,
  input wire logic err_req,
  input wire logic aux_req,
  input wire logic [1:0] aux_val,
  output logic [1:0] clk_src,
  output logic int_clk,
  output logic [7:0] cmd_count,
  output logic auto_ack,
  output logic backchan_err,
  output logic aux_code_valid,
  output logic [1:0] aux_audio_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_src <= 2'h0;
      int_clk <= 1'b0;
      cmd_count <= 8'h00;
    end else if (remote_cmd.valid) begin
      clk_src <= remote_cmd.clk_src;
      int_clk <= remote_cmd.int_clk;
      cmd_count <= cmd_count + 8'h01;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_ack <= 1'b0;
    end else begin
      auto_ack <= auto_ack | auto_ack_req;
    end
  end
  // Mode lines toggle while no aux code is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      backchan_err <= 1'b0;
      aux_code_valid <= 1'b0;
      aux_audio_mode <= 2'h0;
    end else begin
      backchan_err <= err_req;
      aux_code_valid <= aux_req;
      aux_audio_mode <= aux_req ? aux_val : ~aux_audio_mode;
    end
  end
endmodule

// ==== tb_rx_mode_bist_regs.sv ====
// Self-checking bench for the mode and self-test register block
`include "rx_mode_bist_consts.svh"

module tb_rx_mode_bist_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  rx_mode_bist_pkg::strap_t strap = 3'h7;
  rx_mode_bist_pkg::remote_cmd_t remote_cmd;
  logic st_pin = 1'b0;
  logic auto_clk_en = 1'b0;
  logic osc_div_tick = 1'b0;
  logic ack_req = 1'b0;
  logic err_req = 1'b0;
  logic aux_req = 1'b0;
  logic [1:0] aux_val = 2'h0;
  logic bc_err, aux_valid, bc_tick, fast_en, settling, coax, aud_auto;
  logic [1:0] aux_mode, aud_mode, freq, far_clk_src;
  logic freq_ok, st_active, far_int_clk, auto_ack;
  logic [7:0] far_cmds;
  int err_total = 0;
  int checks_done = 0;

  always #2 hclk = ~hclk;

  rx_mode_bist_regs #(.SETTLE_CYC(10)) i_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mode_strap_pin(strap), .self_test_pin(st_pin),
    .auto_clk_en(auto_clk_en), .osc_div_tick(osc_div_tick),
    .backchan_err(bc_err), .aux_code_valid(aux_valid),
    .aux_audio_mode(aux_mode), .backchan_tick(bc_tick),
    .backchan_fast_en(fast_en), .backchan_settling(settling),
    .cable_coax(coax), .audio_auto(aud_auto), .audio_mode(aud_mode),
    .osc_rx_clk_freq(freq), .osc_freq_valid(freq_ok),
    .self_test_active(st_active), .remote_cmd(remote_cmd));

  remote_serializer_model i_far (.hclk(hclk), .hresetn(hresetn),
    .remote_cmd(remote_cmd), .auto_ack_req(ack_req), .err_req(err_req),
    .aux_req(aux_req), .aux_val(aux_val), .clk_src(far_clk_src),
    .int_clk(far_int_clk), .cmd_count(far_cmds), .auto_ack(auto_ack),
    .backchan_err(bc_err), .aux_code_valid(aux_valid),
    .aux_audio_mode(aux_mode));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50) begin
      err_total++;
      $display("ERROR t=%0t bus hang", $time);
      close_out;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdy;
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] m);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q & {24'h0, m}, {24'h0, e});
    chk(32'(hresp), 32'h0);
  endtask

  task automatic count_ticks(input int cy, input int per, output int n);
    n = 0;
    for (int i = 0; i < cy; i++) begin
      @(posedge hclk);
      if (bc_tick === 1'b1) n++;
      osc_div_tick <= (per != 0) && (i % per == 0);
    end
    osc_div_tick <= 1'b0;
  endtask

  task automatic pulse_err;
    err_req <= 1'b1;
    cyc(1);
    err_req <= 1'b0;
    cyc(3);
  endtask

  task automatic aux(input logic [1:0] v);
    aux_req <= 1'b1;
    aux_val <= v;
    cyc(1);
    aux_req <= 1'b0;
    cyc(4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int cmds;
    cyc(20);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    cyc(2);
    rdc(`OFS_RX_MODE, `RX_MODE_RST | 8'h1c, 8'hff);
    rdc(`OFS_SELF_TEST, `SELF_TEST_RST, 8'hff);
    chk(32'(coax), 32'h1);
    chk(32'(fast_en), 32'h1);
    chk(32'(freq_ok), 32'h0);
    wr(`OFS_RX_MODE, 8'h28);
    wr(8'h30, 8'hff);
    rdc(8'h30, 8'h00, 8'hff);
    $display("test reset done");
    count_ticks(48, 3, n);
    chk(32'(n), 32'h4);
    ack_req <= 1'b1;
    cyc(2);
    chk(32'(auto_ack), 32'h1);
    wr(`OFS_RX_MODE, 8'h60);
    cyc(3);
    chk(32'(settling), 32'h1);
    pulse_err;
    rdc(`OFS_STATUS, 8'h00, 8'h04);
    cyc(20);
    count_ticks(48, 3, n);
    chk(32'(n), 32'h8);
    pulse_err;
    rdc(`OFS_STATUS, 8'h04, 8'h06);
    wr(`OFS_STATUS, 8'h04);
    rdc(`OFS_STATUS, 8'h00, 8'h04);
    wr(`OFS_RX_MODE, 8'h70);
    cyc(20);
    chk(32'(fast_en), 32'h1);
    count_ticks(130, 3, n);
    chk(32'(n), 32'ha);
    wr(`OFS_RX_MODE, 8'h30);
    cyc(2);
    chk(32'(settling), 32'h0);
    cyc(20);
    count_ticks(130, 0, n);
    chk(32'(n), 32'ha);
    $display("test rate done");
    wr(`OFS_RX_MODE, 8'h7b);
    rdc(`OFS_RX_MODE, 8'h7f, 8'hff);
    chk(32'(coax), 32'h1);
    wr(`OFS_RX_MODE, 8'h00);
    rdc(`OFS_RX_MODE, 8'h04, 8'hff);
    chk(32'(coax), 32'h0);
    chk(32'(aud_auto), 32'h0);
    aux(2'h1);
    wr(`OFS_RX_MODE, 8'h20);
    aux(2'h2);
    chk(32'(aud_mode), 32'h2);
    wr(`OFS_RX_MODE, 8'h00);
    aux(2'h1);
    chk(32'(aud_mode), 32'h2);
    $display("test mode done");
    auto_clk_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(`OFS_SELF_TEST, 8'(c * 16));
      cyc(3);
      chk(32'(freq), 32'(c < 3 ? c : 2));
      chk(32'(freq_ok), 32'(c != 3));
    end
    wr(`OFS_SELF_TEST, 8'hc0);
    rdc(`OFS_SELF_TEST, 8'hc0, 8'hff);
    $display("test freq done");
    cmds = 0;
    for (int c = 0; c < 4; c++) begin
      wr(`OFS_SELF_TEST, 8'(c * 2 + 1));
      cyc(4);
      cmds++;
      chk(32'(st_active), 32'h1);
      chk(32'(far_clk_src), 32'(c));
      chk(32'(far_int_clk), 32'(c != 0));
      chk(32'(far_cmds), 32'(cmds));
      wr(`OFS_SELF_TEST, 8'h00);
      cyc(3);
      chk(32'(st_active), 32'h0);
    end
    wr(`OFS_SELF_TEST, 8'h09);
    cyc(4);
    chk(32'(st_active), 32'h0);
    st_pin <= 1'b1;
    cyc(4);
    chk(32'(st_active), 32'h1);
    chk(32'(far_cmds), 32'(cmds + 1));
    st_pin <= 1'b0;
    cyc(4);
    chk(32'(st_active), 32'h0);
    $display("test self-test done");
    close_out;
  end
endmodule
